// [design/ncos_sine.v]
// sine table: 13-bit phase to 12-bit offset-binary amplitude
`timescale 1ns/1ns
`include "ncos_map.vh"

module ncos_sine (
    // phase in
    input wire [12:0] phase,
    // amplitude out, combinational
    output wire [11:0] amp
);

// ----------------------------------------------------------------------------
// half-wave magnitude
// ----------------------------------------------------------------------------
// rational sine approximation instead of a stored table: no memory image,
// at the cost of a divider and roughly 0.2 percent peak error
wire [12:0] x;
wire [12:0] rest;
wire [25:0] u;
wire [39:0] num;
wire [27:0] den;
wire [39:0] quot;
wire [10:0] mag;

assign x = {1'b0, phase[11:0]};
assign rest = `NCOS_HALF_CYCLE - x;
assign u = x * rest;
assign num = {14'h0000, u} * `NCOS_AMP_SCALE;
assign den = `NCOS_DEN_BASE - {u, 2'b00};
assign quot = (num + {13'h0000, den[27:1]}) / {12'h000, den};
assign mag = (quot > {29'h0, `NCOS_MAG_MAX}) ? `NCOS_MAG_MAX : quot[10:0];

// ----------------------------------------------------------------------------
// offset binary: upper half of the cycle is negative
// ----------------------------------------------------------------------------
assign amp = phase[12] ? (`NCOS_OUT_MID - {1'b0, mag}) : (`NCOS_OUT_MID + {1'b0, mag});

endmodule

// [design/ncos_top.v]
// numerically controlled oscillator core with serial frequency load and status bus
//
// Our own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ns
`include "ncos_map.vh"

// Notes on behaviour
// - 64-bit frequency register loaded serially, one bit per shift, either direction.
// - direction high: bits enter msb first; low: bits enter lsb first.
// - register shifts on each rising serial clock edge while shift enable is low.
// - word select high passes lower 32 bits, low passes upper 32 bits.
// - transfer low copies the selected word into the accumulator input register.
// - accumulator adds input register each main clock, wrapping on overflow.
// - accumulator enable high holds the accumulator; low lets it step.
// - load low zeroes feedback so accumulator takes the input register value.
// - 2-bit quadrant offset adds to top 13 accumulator bits, addressing the table.
// - phase code zero is 0 degrees, code 0x1000 is 180 degrees.
// - modulation 00,01,10,11 gives 0,90,270,180 degrees.
// - output frequency is word times clock rate over 2 to the 32.
// - table gives offset-binary amplitude 0x001 to 0xfff, centred on 0x800.
// - transfer sampled on main clock, acts four clocks later.
// - modulation inputs act after four main clocks.
// - accumulator enable acts after four main clocks.
// - load acts after five main clocks.
module ncos_top #(
    parameter FREQ_W = `NCOS_FREQ_W,
    parameter WORD_W = `NCOS_WORD_W,
    parameter PHASE_W = `NCOS_PHASE_W,
    parameter OUT_W = `NCOS_OUT_W,
    parameter WORD_TRANSFER_N_DLY = `NCOS_WORD_TRANSFER_N_DLY,
    parameter MOD_DLY = `NCOS_MOD_DLY,
    parameter ENA_DLY = `NCOS_ENA_DLY,
    parameter LOAD_DLY = `NCOS_LOAD_DLY
) (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // serial frequency load
    input wire shift_clk,
    input wire shift_enable_n,
    input wire serial_data_in,
    input wire shift_msb_first,
    // word selection, accumulator and phase modulation control
    input wire word_sel_low,
    input wire word_transfer_n,
    input wire accum_enable_n,
    input wire accum_load_n,
    input wire [1:0] phase_mod_bits,
    // amplitude
    output reg [OUT_W-1:0] sine_out,
    // axi4-lite write address
    input wire [`NCOS_AXI_AW-1:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // axi4-lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read address
    input wire [`NCOS_AXI_AW-1:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    // axi4-lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);

// ----------------------------------------------------------------------------
// serial frequency register
// ----------------------------------------------------------------------------
// shift clock is an ordinary input sampled by aclk, so it must stay high and
// low for at least one aclk period each
reg [FREQ_W-1:0] freq_reg;
reg shift_clk_q;
wire shift_edge;

assign shift_edge = shift_clk & ~shift_clk_q;

always @(posedge aclk) begin
    if (!aresetn) begin
        shift_clk_q <= 1'b0;
    end else begin
        shift_clk_q <= shift_clk;
    end
end

always @(posedge aclk) begin
    if (!aresetn) begin
        freq_reg <= {FREQ_W{1'b0}};
    end else if (shift_edge && !shift_enable_n) begin
        if (shift_msb_first) begin
            freq_reg <= {freq_reg[FREQ_W-2:0], serial_data_in};
        end else begin
            // lsb-first data enters at the top and walks down
            freq_reg <= {serial_data_in, freq_reg[FREQ_W-1:1]};
        end
    end
end

// ----------------------------------------------------------------------------
// word multiplexer
// ----------------------------------------------------------------------------
wire [WORD_W-1:0] sel_word;

assign sel_word = word_sel_low ? freq_reg[WORD_W-1:0] : freq_reg[FREQ_W-1:WORD_W];

// ----------------------------------------------------------------------------
// control pipelines
// ----------------------------------------------------------------------------
// active-low strobes fill with ones so nothing fires straight after reset
reg [WORD_TRANSFER_N_DLY-1:0] word_transfer_n_pipe;
reg [ENA_DLY-1:0] ena_pipe;
reg [LOAD_DLY-1:0] load_pipe;
reg [2*MOD_DLY-1:0] mod_pipe;
wire word_transfer_n_act_n;
wire ena_act_n;
wire load_act_n;
wire [1:0] mod_act;

always @(posedge aclk) begin
    if (!aresetn) begin
        word_transfer_n_pipe <= {WORD_TRANSFER_N_DLY{1'b1}};
        ena_pipe <= {ENA_DLY{1'b1}};
        load_pipe <= {LOAD_DLY{1'b1}};
        mod_pipe <= {(2*MOD_DLY){1'b0}};
    end else begin
        word_transfer_n_pipe <= {word_transfer_n_pipe[WORD_TRANSFER_N_DLY-2:0], word_transfer_n};
        ena_pipe <= {ena_pipe[ENA_DLY-2:0], accum_enable_n};
        load_pipe <= {load_pipe[LOAD_DLY-2:0], accum_load_n};
        mod_pipe <= {mod_pipe[2*MOD_DLY-3:0], phase_mod_bits};
    end
end

assign word_transfer_n_act_n = word_transfer_n_pipe[WORD_TRANSFER_N_DLY-1];
assign ena_act_n = ena_pipe[ENA_DLY-1];
assign load_act_n = load_pipe[LOAD_DLY-1];
assign mod_act = mod_pipe[2*MOD_DLY-1:2*MOD_DLY-2];

// ----------------------------------------------------------------------------
// phase accumulator
// ----------------------------------------------------------------------------
reg [WORD_W-1:0] acc_in;
reg [WORD_W-1:0] accum;
reg ctrl_hold;
wire [WORD_W-1:0] feedback;

always @(posedge aclk) begin
    if (!aresetn) begin
        acc_in <= {WORD_W{1'b0}};
    end else if (!word_transfer_n_act_n) begin
        acc_in <= sel_word;
    end
end

assign feedback = load_act_n ? accum : {WORD_W{1'b0}};

// software hold stacks on top of the pin, it cannot force stepping on
always @(posedge aclk) begin
    if (!aresetn) begin
        accum <= {WORD_W{1'b0}};
    end else if (!ena_act_n && !ctrl_hold) begin
        accum <= feedback + acc_in;
    end
end

// ----------------------------------------------------------------------------
// phase offset and output
// ----------------------------------------------------------------------------
reg [1:0] quad;
wire [PHASE_W-1:0] phase;
wire [OUT_W-1:0] table_amp;

always @* begin
    case (mod_act)
        2'b00: quad = `NCOS_QUAD_0;
        2'b01: quad = `NCOS_QUAD_90;
        2'b10: quad = `NCOS_QUAD_270;
        default: quad = `NCOS_QUAD_180;
    endcase
end

assign phase = accum[WORD_W-1:WORD_W-PHASE_W] + {quad, {(PHASE_W-2){1'b0}}};

ncos_sine ncos_sine_i (
    .phase(phase),
    .amp(table_amp)
);

always @(posedge aclk) begin
    if (!aresetn) begin
        sine_out <= `NCOS_OUT_MID;
    end else begin
        sine_out <= table_amp;
    end
end

// ----------------------------------------------------------------------------
// axi4-lite write path
// ----------------------------------------------------------------------------
reg aw_got;
reg w_got;
reg [`NCOS_AXI_AW-1:0] aw_addr;
reg [31:0] w_data;
reg [3:0] w_strb;

always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_awready <= 1'b0;
        aw_got <= 1'b0;
        aw_addr <= {`NCOS_AXI_AW{1'b0}};
    end else if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_got <= 1'b1;
        aw_addr <= s_axi_awaddr;
    end else if (aw_got && w_got && !s_axi_bvalid) begin
        aw_got <= 1'b0;
    end else if (!aw_got && !s_axi_bvalid && !s_axi_awready) begin
        s_axi_awready <= 1'b1;
    end
end

always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_wready <= 1'b0;
        w_got <= 1'b0;
        w_data <= 32'h00000000;
        w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_got <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
    end else if (aw_got && w_got && !s_axi_bvalid) begin
        w_got <= 1'b0;
    end else if (!w_got && !s_axi_bvalid && !s_axi_wready) begin
        s_axi_wready <= 1'b1;
    end
end

// only the control word is writable; other words answer slverr
always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `NCOS_RESP_OKAY;
        ctrl_hold <= `NCOS_CTRL_RESET;
    end else if (aw_got && w_got && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        if ({aw_addr[`NCOS_AXI_AW-1:2], 2'b00} == `NCOS_REG_CTRL) begin
            s_axi_bresp <= `NCOS_RESP_OKAY;
            if (w_strb[0]) begin
                ctrl_hold <= w_data[`NCOS_CTRL_HOLD];
            end
        end else begin
            s_axi_bresp <= `NCOS_RESP_SLVERR;
        end
    end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
    end
end

// ----------------------------------------------------------------------------
// axi4-lite read path
// ----------------------------------------------------------------------------
wire [`NCOS_AXI_AW-3:0] rd_idx;

assign rd_idx = s_axi_araddr[`NCOS_AXI_AW-1:2];

always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= `NCOS_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `NCOS_RESP_OKAY;
        if ({rd_idx, 2'b00} == `NCOS_REG_CTRL) begin
            s_axi_rdata <= {31'h00000000, ctrl_hold};
        end else if ({rd_idx, 2'b00} == `NCOS_REG_STATUS) begin
            s_axi_rdata <= {{(32-OUT_W){1'b0}}, sine_out};
        end else if ({rd_idx, 2'b00} == `NCOS_REG_FWORD) begin
            s_axi_rdata <= acc_in;
        end else if ({rd_idx, 2'b00} == `NCOS_REG_PHASE) begin
            s_axi_rdata <= accum;
        end else begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `NCOS_RESP_SLVERR;
        end
    end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
    end else if (!s_axi_rvalid && !s_axi_arready) begin
        s_axi_arready <= 1'b1;
    end
end

endmodule

// [include/ncos_map.vh]
// constants shared by the oscillator core and its sine table
`ifndef NCOS_MAP_VH
`define NCOS_MAP_VH

// ----------------------------------------------------------------------------
// widths
// ----------------------------------------------------------------------------
`define NCOS_FREQ_W 64
`define NCOS_WORD_W 32
`define NCOS_PHASE_W 13
`define NCOS_OUT_W 12
`define NCOS_AXI_AW 8

// ----------------------------------------------------------------------------
// pipeline delays in main clocks
// ----------------------------------------------------------------------------
`define NCOS_WORD_TRANSFER_N_DLY 4
`define NCOS_MOD_DLY 4
`define NCOS_ENA_DLY 4
`define NCOS_LOAD_DLY 5

// ----------------------------------------------------------------------------
// phase offsets as quadrant numbers, added to the top two phase bits
// ----------------------------------------------------------------------------
`define NCOS_QUAD_0 2'h0
`define NCOS_QUAD_90 2'h1
`define NCOS_QUAD_180 2'h2
`define NCOS_QUAD_270 2'h3

// ----------------------------------------------------------------------------
// sine table scaling
// ----------------------------------------------------------------------------
`define NCOS_HALF_CYCLE 13'h1000
`define NCOS_OUT_MID 12'h800
`define NCOS_MAG_MAX 11'h7ff
`define NCOS_AMP_SCALE 40'h0000007ff0
`define NCOS_DEN_BASE 28'h5000000

// ----------------------------------------------------------------------------
// register map (byte addresses) and fields
// ----------------------------------------------------------------------------
`define NCOS_REG_CTRL 8'h00
`define NCOS_REG_STATUS 8'h04
`define NCOS_REG_FWORD 8'h08
`define NCOS_REG_PHASE 8'h0c
`define NCOS_CTRL_HOLD 0
`define NCOS_CTRL_RESET 1'b0
`define NCOS_RESP_OKAY 2'h0
`define NCOS_RESP_SLVERR 2'h2

`endif

// [verif/nco_sine_synthesizer_test.sv]
// self-checking bench for the oscillator core
`timescale 1ns/1ns
`include "ncos_map.vh"
module nco_sine_synthesizer_test;
    reg aclk = 1'b0;
    reg aresetn = 1'b0;
    reg word_sel_low = 1'b1, word_transfer_n = 1'b1, accum_enable_n = 1'b0, accum_load_n = 1'b1;
    reg [1:0] phase_mod_bits = 2'h0;
    reg [7:0] awaddr = 8'h00, araddr = 8'h00;
    reg [31:0] wdata = 32'h0, wa, wb, d, p1, p3, seed_v;
    reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    wire shift_clk, shift_enable_n, serial_data_in, shift_msb_first;
    wire awready, wready, bvalid, arready, rvalid;
    wire [1:0] bresp, rresp;
    wire [11:0] sine_out;
    wire [31:0] rdata;
    reg [33:0] exp_q[$];
    integer tol_q[$];
    reg [33:0] e;
    integer t, q, bad_count = 0, samples_checked = 0;
    always #10 aclk = ~aclk;
    nss_host_model nss_host_model_i (.aclk(aclk), .shift_clk(shift_clk),
        .shift_enable_n(shift_enable_n), .serial_data_in(serial_data_in),
        .shift_msb_first(shift_msb_first));
    ncos_top ncos_top_i (.aclk(aclk), .aresetn(aresetn), .shift_clk(shift_clk),
        .shift_enable_n(shift_enable_n), .serial_data_in(serial_data_in),
        .shift_msb_first(shift_msb_first), .word_sel_low(word_sel_low),
        .word_transfer_n(word_transfer_n), .accum_enable_n(accum_enable_n),
        .accum_load_n(accum_load_n), .phase_mod_bits(phase_mod_bits), .sine_out(sine_out),
        .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));
    // ------------------------------------------------------------
    // comparison, bus tasks and read monitor
    // ------------------------------------------------------------
    task check(input [63:0] nm, input [31:0] s, input [31:0] x, input integer tl);
        begin
            samples_checked = samples_checked + 1;
            if (s !== x && (tl == 0 || $isunknown(s) || (s > x ? s - x : x - s) > tl)) begin
                bad_count = bad_count + 1;
                $display("[FAIL] %0s expected %h seen %h", nm, x, s);
            end
        end
    endtask
    task rd(input [7:0] a, input [33:0] x, input integer tl, output [31:0] v);
        begin
            exp_q.push_back(x);
            tol_q.push_back(tl);
            @(posedge aclk);
            araddr <= a;
            arvalid <= 1'b1;
            do @(posedge aclk); while (arready !== 1'b1);
            arvalid <= 1'b0;
            rready <= 1'b1;
            do @(posedge aclk); while (rvalid !== 1'b1);
            v = rdata;
            rready <= 1'b0;
        end
    endtask
    task wr(input [7:0] a, input [31:0] v, input [1:0] er);
        begin
            @(posedge aclk);
            awaddr <= a;
            wdata <= v;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            do begin
                @(posedge aclk);
                if (awready === 1'b1) awvalid <= 1'b0;
                if (wready === 1'b1) wvalid <= 1'b0;
            end while (awvalid || wvalid);
            bready <= 1'b1;
            do @(posedge aclk); while (bvalid !== 1'b1);
            check("bresp", {30'h0, bresp}, {30'h0, er}, 0);
            bready <= 1'b0;
        end
    endtask
    task xfer(input sel);
        begin
            @(posedge aclk);
            word_sel_low <= sel;
            word_transfer_n <= 1'b0;
            @(posedge aclk);
            word_transfer_n <= 1'b1;
            repeat (8) @(posedge aclk);
        end
    endtask
    always @(posedge aclk) begin
        if (rvalid === 1'b1 && rready === 1'b1 && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            t = tol_q.pop_front();
            check("rresp", {30'h0, rresp}, {30'h0, e[33:32]}, 0);
            if (t >= 0) check("rdata", rdata, e[31:0], t);
        end
    end
    task tally_and_finish;
        begin
            $display("checked %0d mismatches %0d", samples_checked, bad_count);
            if (bad_count == 0 && samples_checked > 0) $display("TEST PASSED");
            else $display("TEST FAILED");
            $finish;
        end
    endtask
    initial begin
        #(20 * 40000);
        bad_count = bad_count + 1;
        tally_and_finish;
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        seed_v = $urandom(32'h7fd232be);
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        check("sine", {20'h0, sine_out}, 32'h800, 0);
        rd(`NCOS_REG_CTRL, 34'h0, 0, d);
        wa = $urandom;
        nss_host_model_i.load(wa, 1'b1, 1'b0);
        xfer(1'b1);
        rd(`NCOS_REG_FWORD, {2'h0, wa}, 0, d);
        wb = ($urandom & 32'h000fffff) | 32'h100;
        nss_host_model_i.load(wb, 1'b0, 1'b0);
        xfer(1'b0);
        rd(`NCOS_REG_FWORD, {2'h0, wb}, 0, d);
        accum_load_n <= 1'b0;
        repeat (8) @(posedge aclk);
        accum_load_n <= 1'b1;
        accum_enable_n <= 1'b1;
        repeat (8) @(posedge aclk);
        rd(`NCOS_REG_PHASE, {2'h0, wb}, 0, p1);
        rd(`NCOS_REG_PHASE, {2'h0, wb}, 0, d);
        accum_enable_n <= 1'b0;
        repeat (20) @(posedge aclk);
        accum_enable_n <= 1'b1;
        repeat (8) @(posedge aclk);
        rd(`NCOS_REG_PHASE, {2'h0, 32'h0}, -1, p3);
        check("step", p3, p1 + 32'd20 * wb, 0);
        // software hold must freeze the accumulator while the pin lets it step
        wr(`NCOS_REG_CTRL, 32'h1, `NCOS_RESP_OKAY);
        rd(`NCOS_REG_CTRL, 34'h1, 0, d);
        accum_enable_n <= 1'b0;
        repeat (8) @(posedge aclk);
        rd(`NCOS_REG_PHASE, {2'h0, p3}, 0, d);
        wr(`NCOS_REG_CTRL, 32'h0, `NCOS_RESP_OKAY);
        accum_enable_n <= 1'b1;
        nss_host_model_i.load(~wb, 1'b0, 1'b1);
        xfer(1'b0);
        rd(`NCOS_REG_FWORD, {2'h0, wb}, 0, d);
        xfer(1'b1);
        rd(`NCOS_REG_FWORD, 34'h0, 0, d);
        wr(`NCOS_REG_STATUS, 32'h5, `NCOS_RESP_SLVERR);
        rd(8'h40, {`NCOS_RESP_SLVERR, 32'h0}, 0, d);
        accum_enable_n <= 1'b0;
        accum_load_n <= 1'b0;
        repeat (8) @(posedge aclk);
        accum_load_n <= 1'b1;
        for (q = 0; q < 4; q = q + 1) begin
            phase_mod_bits <= q[1:0];
            repeat (8) @(posedge aclk);
            rd(`NCOS_REG_STATUS, {22'h0, q == 1 ? 12'hfff : q == 2 ? 12'h001 : 12'h800}, 5,
                d);
        end
        repeat (4) @(posedge aclk);
        tally_and_finish;
    end
endmodule

// [verif/nss_host_model.sv]
// host controller model driving the serial frequency load pins
`timescale 1ns/1ns
module nss_host_model (
    // clock
    input wire aclk,
    // serial load pins
    output reg shift_clk,
    output reg shift_enable_n,
    output reg serial_data_in,
    output reg shift_msb_first
);
    reg busy = 1'b0;
    reg frame_bit = 1'b0;
    integer i;
    initial begin
        shift_clk = 1'b0;
        shift_enable_n = 1'b1;
        serial_data_in = 1'b0;
        shift_msb_first = 1'b1;
    end
    // data line is not held between frames, so nothing leans on a stale bit
    // single driver of the data line; frame bits reach it one edge late,
    // still one edge ahead of the rising shift clock
    always @(posedge aclk) begin
        if (busy) serial_data_in <= frame_bit;
        else serial_data_in <= ~serial_data_in;
    end
    task load(input [31:0] w, input msb, input en_n);
        begin
            @(posedge aclk);
            busy <= 1'b1;
            shift_msb_first <= msb;
            shift_enable_n <= en_n;
            for (i = 0; i < 32; i = i + 1) begin
                @(posedge aclk);
                shift_clk <= 1'b0;
                frame_bit <= msb ? w[31-i] : w[i];
                repeat (2) @(posedge aclk);
                shift_clk <= 1'b1;
                @(posedge aclk);
            end
            @(posedge aclk);
            shift_clk <= 1'b0;
            shift_enable_n <= 1'b1;
            busy <= 1'b0;
        end
    endtask
endmodule

// [verif/nss_top_sva.sv]
// assertion checker for the oscillator top ports
`timescale 1ns/1ns
`include "ncos_map.vh"
module nss_checker #(
    parameter OUT_W = 12
) (
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // amplitude
    input wire [OUT_W-1:0] sine_out,
    // register bus
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_awready,
    input wire s_axi_wready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [`NCOS_AXI_AW-1:0] s_axi_araddr,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    reset_mid_a: assert property ($rose(aresetn) |-> sine_out == 12'h800)
        else $error("sine output not mid scale after reset");
    out_range_a: assert property (sine_out != 12'h000)
        else $error("sine output below range");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    b_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response not cleared");
    b_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("new write taken during response");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read data changed before taken");
    r_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    // word index decides: bytes 0x0d..0x0f still fall in the last mapped word
    unmapped_read_a: assert property (s_axi_arvalid && s_axi_arready &&
        {s_axi_araddr[`NCOS_AXI_AW-1:2], 2'b00} > `NCOS_REG_PHASE |=>
        s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    cover property (s_axi_arvalid && s_axi_arready);
    cover property (s_axi_bvalid && s_axi_bready);
    cover property (sine_out > 12'hff0);
endmodule
bind ncos_top nss_checker #(.OUT_W(OUT_W)) nss_checker_i (.aclk(aclk), .aresetn(aresetn),
    .sine_out(sine_out), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp));
